// *** rtl/ppr_pkg.sv ***
// Package for the port pull resistor register bank: offsets, masks, reset values, wait counts.
// Assumes a 32-bit APB slave with byte addresses and word-aligned registers.
package ppr_pkg;
  localparam logic [11:0] PPR_OFF_PB_PD = 12'h02C;
  localparam logic [11:0] PPR_OFF_PC_PU = 12'h030;
  localparam logic [11:0] PPR_OFF_PC_PD = 12'h034;
  localparam logic [11:0] PPR_OFF_PD_PU = 12'h038;
  localparam logic [11:0] PPR_OFF_PD_PD = 12'h03C;
  localparam logic [11:0] PPR_OFF_PF_PU = 12'h048;
  localparam logic [11:0] PPR_OFF_PF_PD = 12'h04C;
  localparam logic [15:0] PPR_MASK_B = 16'hFFFF;
  localparam logic [15:0] PPR_MASK_C = 16'hFFFF;
  localparam logic [15:0] PPR_MASK_D = 16'h037F;
  localparam logic [15:0] PPR_MASK_F = 16'h0007;
  localparam logic [15:0] PPR_RESET_VAL = 16'h0000;
  localparam logic [1:0] PPR_WAIT_WRITE = 2'h3;
  localparam logic [1:0] PPR_WAIT_READ = 2'h2;
endpackage

// *** rtl/ppr_regs.sv ***
// Port pull resistor enable register bank with APB slave and gated pull outputs.
// Assumes APB signals from the same clock domain; apply_pull_config_i comes from power_control_three logic.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Port B pull-down bits 15:0 drive port B pull-downs while apply bit set.
// - Port C pull-up bits 15:0 drive port C pull-ups while apply bit set.
// - Port C pull-down bits 15:0 drive port C pull-downs while apply bit set.
// - Port D pull-up implements bits 9:8 and 6:0; others reserved.
// - Port D pull-down implements bits 9:8 and 6:0, gated by apply bit.
// - Port F pull-up implements bits 2:0 only, gated by apply bit.
// - Port F pull-down implements bits 2:0 only, gated by apply bit.
// - Pull-down wins; pull-up suppressed when both enabled on a pin.
// - All enable registers are zero after full reset.
// - Registers ignore Standby exit and power block peripheral reset.
module ppr_regs
  import ppr_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic apply_pull_config_i,
  input wire logic standby_exit_i,
  input wire logic power_block_peripheral_reset_i,
  output logic [15:0] port_b_pulldown_o,
  output logic [15:0] port_c_pullup_o,
  output logic [15:0] port_c_pulldown_o,
  output logic [15:0] port_d_pullup_o,
  output logic [15:0] port_d_pulldown_o,
  output logic [15:0] port_f_pullup_o,
  output logic [15:0] port_f_pulldown_o
);

  localparam int NREG = 7;
  localparam logic [11:0] OFFS [NREG] = '{PPR_OFF_PB_PD, PPR_OFF_PC_PU, PPR_OFF_PC_PD,
    PPR_OFF_PD_PU, PPR_OFF_PD_PD, PPR_OFF_PF_PU, PPR_OFF_PF_PD};
  localparam logic [15:0] MASKS [NREG] = '{PPR_MASK_B, PPR_MASK_C, PPR_MASK_C,
    PPR_MASK_D, PPR_MASK_D, PPR_MASK_F, PPR_MASK_F};

  logic [15:0] enable_r [NREG];
  logic [1:0] wait_r;
  logic [NREG-1:0] hit;
  logic access;
  logic done;
  logic [31:0] rd_nxt;

  // Standby exit and peripheral reset are deliberately not connected to storage
  logic unused_resets;
  assign unused_resets = standby_exit_i | power_block_peripheral_reset_i;

  assign access = psel_i & penable_i & ~pready_o;
  assign done = access & (wait_r == (pwrite_i ? PPR_WAIT_WRITE : PPR_WAIT_READ));

  // Extra wait states count up during the access phase
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wait_r <= 2'h0;
    end else if (done || !access) begin
      wait_r <= 2'h0;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= done;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      assign hit[g] = (paddr_i == OFFS[g]);
      always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
          enable_r[g] <= PPR_RESET_VAL;
        end else if (done && pwrite_i && hit[g]) begin
          enable_r[g] <= pwdata_i[15:0] & MASKS[g];
        end
      end
    end
  endgenerate

  // Read decode; unmapped offsets fall through to zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit[0]) begin
      rd_nxt = {16'h0000, enable_r[0]};
    end else if (hit[1]) begin
      rd_nxt = {16'h0000, enable_r[1]};
    end else if (hit[2]) begin
      rd_nxt = {16'h0000, enable_r[2]};
    end else if (hit[3]) begin
      rd_nxt = {16'h0000, enable_r[3]};
    end else if (hit[4]) begin
      rd_nxt = {16'h0000, enable_r[4]};
    end else if (hit[5]) begin
      rd_nxt = {16'h0000, enable_r[5]};
    end else if (hit[6]) begin
      rd_nxt = {16'h0000, enable_r[6]};
    end
  end

  // Read data stands only in the cycle that pready is high
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (done && !pwrite_i) begin
      prdata_o <= rd_nxt;
    end else begin
      prdata_o <= 32'h0000_0000;
    end
  end

  // No access is ever refused
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= 1'b0;
    end
  end

  // Pull-down wins on a pin with both enables set
  logic [15:0] c_pullup_eff;
  logic [15:0] d_pullup_eff;
  logic [15:0] f_pullup_eff;
  assign c_pullup_eff = enable_r[1] & ~enable_r[2];
  assign d_pullup_eff = enable_r[3] & ~enable_r[4];
  assign f_pullup_eff = enable_r[5] & ~enable_r[6];

  // Each port output is gated by the apply bit
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      port_b_pulldown_o <= PPR_RESET_VAL;
    end else if (apply_pull_config_i) begin
      port_b_pulldown_o <= enable_r[0];
    end else begin
      port_b_pulldown_o <= PPR_RESET_VAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      port_c_pullup_o <= PPR_RESET_VAL;
    end else if (apply_pull_config_i) begin
      port_c_pullup_o <= c_pullup_eff;
    end else begin
      port_c_pullup_o <= PPR_RESET_VAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      port_c_pulldown_o <= PPR_RESET_VAL;
    end else if (apply_pull_config_i) begin
      port_c_pulldown_o <= enable_r[2];
    end else begin
      port_c_pulldown_o <= PPR_RESET_VAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      port_d_pullup_o <= PPR_RESET_VAL;
    end else if (apply_pull_config_i) begin
      port_d_pullup_o <= d_pullup_eff;
    end else begin
      port_d_pullup_o <= PPR_RESET_VAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      port_d_pulldown_o <= PPR_RESET_VAL;
    end else if (apply_pull_config_i) begin
      port_d_pulldown_o <= enable_r[4];
    end else begin
      port_d_pulldown_o <= PPR_RESET_VAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      port_f_pullup_o <= PPR_RESET_VAL;
    end else if (apply_pull_config_i) begin
      port_f_pullup_o <= f_pullup_eff;
    end else begin
      port_f_pullup_o <= PPR_RESET_VAL;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      port_f_pulldown_o <= PPR_RESET_VAL;
    end else if (apply_pull_config_i) begin
      port_f_pulldown_o <= enable_r[6];
    end else begin
      port_f_pulldown_o <= PPR_RESET_VAL;
    end
  end

endmodule
`default_nettype wire

// *** testbench/ppr_assertions.sv ***
// Checker on the pull bank ports.
// Bound into ppr_regs; one clock.
`timescale 1ns/10ps
`default_nettype none
module ppr_chk
  import ppr_pkg::*;
(
  input wire logic clk_i, nrst_i, penable_i, pwrite_i, pready_o, pslverr_o, apply_pull_config_i,
  input wire logic [31:0] prdata_o,
  input wire logic [15:0] port_b_pulldown_o, port_c_pullup_o, port_c_pulldown_o, port_d_pullup_o,
  input wire logic [15:0] port_d_pulldown_o, port_f_pullup_o, port_f_pulldown_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_wr_waits: assert property ($rose(penable_i) && pwrite_i |-> !pready_o [*4] ##1 pready_o)
    else $error("wr wait");
  a_rd_waits: assert property ($rose(penable_i) && !pwrite_i |-> !pready_o [*3] ##1 pready_o)
    else $error("rd wait");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("rdy");
  a_no_err: assert property (!pslverr_o) else $error("err");
  a_rd_idle: assert property (!pready_o |-> prdata_o == 32'h0) else $error("rdata");
  a_pull_gated: assert property (!apply_pull_config_i |=>
    (port_b_pulldown_o | port_c_pullup_o | port_c_pulldown_o) == 16'h0) else $error("gate");
  a_pd_wins: assert property ((port_c_pullup_o & port_c_pulldown_o) == 16'h0) else $error("win");
  a_d_mask: assert property (((port_d_pullup_o | port_d_pulldown_o) & ~PPR_MASK_D) == 16'h0)
    else $error("d mask");
  a_f_mask: assert property (((port_f_pullup_o | port_f_pulldown_o) & ~PPR_MASK_F) == 16'h0)
    else $error("f mask");
  c_wr: cover property ($rose(penable_i) && pwrite_i);
  c_rd: cover property (pready_o && prdata_o != 32'h0);
  c_pull: cover property (port_c_pullup_o != 16'h0);
endmodule
bind ppr_regs ppr_chk u_chk (.*);
`default_nettype wire

// *** testbench/ppr_regs_tb.sv ***
// Bench for the pull bank: bus access, masks, gating, retention.
// Drives all ppr_regs inputs itself.
`timescale 1ns/10ps
`default_nettype none
module ppr_regs_tb;
  import ppr_pkg::*;
  logic clk_i = 1'h0, nrst_i = 1'h0, psel_i = 1'h0, penable_i = 1'h0, pwrite_i = 1'h0;
  logic apply_pull_config_i = 1'h0, standby_exit_i = 1'h0, power_block_peripheral_reset_i = 1'h0;
  logic pready_o, pslverr_o, e;
  int lat = 0;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, q;
  logic [15:0] port_b_pulldown_o, port_c_pullup_o, port_c_pulldown_o, port_d_pullup_o, port_d_pulldown_o;
  logic [15:0] port_f_pullup_o, port_f_pulldown_o;
  logic [11:0] offs [7] = '{PPR_OFF_PB_PD, PPR_OFF_PC_PU, PPR_OFF_PC_PD, PPR_OFF_PD_PU, PPR_OFF_PD_PD,
    PPR_OFF_PF_PU, PPR_OFF_PF_PD};
  logic [15:0] msk [7] = '{PPR_MASK_B, PPR_MASK_C, PPR_MASK_C, PPR_MASK_D, PPR_MASK_D, PPR_MASK_F, PPR_MASK_F};
  int errors = 0, n_checks = 0, cyc = 0;
  ppr_regs dut_u (.*);
  always #20 clk_i = ~clk_i;
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) if (++cyc == 2000) begin errors++; wrap_up(); end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin errors++; $display("unexpected %0t got %h exp %h", $time, got, exp); end
  endtask
  // Holds setup and access until pready is sampled
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'h1; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'h1;
    for (int i = 0; i < 8; i++) begin @(posedge clk_i); lat = i; if (pready_o === 1'h1) break; end
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'h0; penable_i <= 1'h0;
  endtask
  task automatic t_reset();
    foreach (offs[i]) begin bus(1'h0, offs[i], 32'h0); chk(q, 32'h0); end
    chk({31'h0, e}, 32'h0);
    chk({port_b_pulldown_o, port_c_pullup_o}, 32'h0);
    $display("reset done");
  endtask
  task automatic t_masks();
    foreach (offs[i]) begin
      bus(1'h1, offs[i], {16'h0, msk[i]});
      chk(lat, 32'h4);
      bus(1'h0, offs[i], 32'h0);
      chk(lat, 32'h3);
      chk(q, {16'h0, msk[i]});
    end
    bus(1'h1, 12'h040, 32'h0000FFFF);
    bus(1'h0, 12'h040, 32'h0);
    chk(q, 32'h0);
    $display("masks done");
  endtask
  task automatic t_pull();
    apply_pull_config_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    chk({port_b_pulldown_o, port_c_pullup_o}, 32'hFFFF0000);
    chk({port_d_pulldown_o, port_c_pulldown_o}, 32'h037FFFFF);
    chk({port_d_pullup_o, port_f_pulldown_o}, 32'h00000007);
    bus(1'h1, PPR_OFF_PC_PD, 32'h0);
    bus(1'h1, PPR_OFF_PD_PD, 32'h0);
    bus(1'h1, PPR_OFF_PF_PD, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({port_c_pullup_o, port_f_pullup_o}, 32'hFFFF0007);
    chk({16'h0, port_d_pullup_o}, 32'h037F);
    $display("pull done");
  endtask
  task automatic t_retain();
    standby_exit_i <= 1'h1; power_block_peripheral_reset_i <= 1'h1;
    @(posedge clk_i);
    standby_exit_i <= 1'h0; power_block_peripheral_reset_i <= 1'h0;
    bus(1'h0, PPR_OFF_PC_PU, 32'h0);
    chk(q, 32'hFFFF);
    apply_pull_config_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    chk({port_b_pulldown_o, port_c_pullup_o}, 32'h0);
    chk({port_d_pullup_o, port_f_pullup_o}, 32'h0);
    $display("retain done");
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'h1;
    t_reset();
    t_masks();
    t_pull();
    t_retain();
    wrap_up();
  end
endmodule
`default_nettype wire
